// ---- core/pmac_config.sv ----
// Purpose: Media select, strap config and negotiation control/status
// Assumes: Partner pages arrive decoded; detect links come from PMAs
// Notes: Straps are caught on the first clock after reset release
`timescale 1ns/1ps
module pmac_config
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_rxerr_strap,
	input wire logic i_negotiation_strap_enable,
	input wire logic i_ability_strap_high,
	input wire logic i_ability_strap_low,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [4:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_page_valid,
	input wire logic [15:0] i_page_word,
	input wire logic i_pd_link_100,
	input wire logic i_pd_link_10,
	input wire logic i_link_good,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_flp_enable,
	output logic [15:0] o_adv_word,
	output logic o_speed_100,
	output logic o_full_duplex,
	output logic o_link_up,
	output logic o_fiber_mode,
	output logic o_fef_enable,
	output logic o_scr_bypass,
	output logic o_descr_bypass
);
	typedef struct packed {
		pmac_pkg::pmac_an_st_t st;
		logic strap_done;
		logic negotiation_strap_enable;
		logic speed;
		logic duplex;
		logic [3:0] negotiation_advertisement;
		logic fiber;
		logic fef;
		logic scr_byp;
		logic descr_byp;
		logic [15:0] lpar;
		logic an_cpl;
		logic page_rx;
		logic pd_fault;
		logic lp_an_able;
		logic res_spd;
		logic res_fd;
		logic [15:0] rdata;
		logic rvalid;
		logic flp;
		logic [15:0] adv;
		logic spd;
		logic fd;
		logic link;
	} pmac_state_t;

	pmac_state_t state_reg;
	pmac_state_t state_next;
	logic res_valid;
	logic res_spd;
	logic res_fd;

	pmac_resolve u_resolve
	(
		.i_local(state_reg.negotiation_advertisement),
		.i_partner(i_page_word[8:5]),
		.o_valid(res_valid),
		.o_speed_100(res_spd),
		.o_full(res_fd)
	);

	always_comb
	begin
		logic restart;
		logic an_start;
		logic an_mode;
		logic [15:0] rd;
		restart = 1'b0;
		an_start = 1'b0;
		an_mode = 1'b0;
		rd = 16'h0000;
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		if (!state_reg.strap_done)
		begin
			// Straps only load here; later writes stand until reset
			state_next.strap_done = 1'b1;
			state_next.fiber = !i_rxerr_strap;
			state_next.fef = !i_rxerr_strap;
			state_next.scr_byp = !i_rxerr_strap;
			state_next.descr_byp = !i_rxerr_strap;
			state_next.negotiation_strap_enable = i_negotiation_strap_enable;
			state_next.speed = i_ability_strap_high;
			state_next.duplex = i_ability_strap_low;
			state_next.negotiation_advertisement = pmac_pkg::ADV_ALL;
			if (i_negotiation_strap_enable)
			begin
				state_next.st = pmac_pkg::PMAC_AN_ACTIVE;
				case ({i_ability_strap_high, i_ability_strap_low})
					2'b00: state_next.negotiation_advertisement = pmac_pkg::ADV_10_HF;
					2'b01: state_next.negotiation_advertisement = pmac_pkg::ADV_100_HF;
					2'b10: state_next.negotiation_advertisement = pmac_pkg::ADV_100_F;
					default: state_next.negotiation_advertisement = pmac_pkg::ADV_ALL;
				endcase
			end
		end
		else
		begin
			if (i_reg_wr)
			begin
				case (i_reg_addr)
					pmac_pkg::ADDR_BMCTL:
					begin
						state_next.negotiation_strap_enable = i_reg_wdata[pmac_pkg::BMCTL_NEGOTIATION_STRAP_ENABLE];
						state_next.speed = i_reg_wdata[pmac_pkg::BMCTL_SPEED];
						state_next.duplex = i_reg_wdata[pmac_pkg::BMCTL_DUPLEX];
						restart = i_reg_wdata[pmac_pkg::BMCTL_RESTART];
						// Forced to negotiating needs a clear-then-set of enable
						an_start = !state_reg.negotiation_strap_enable &&
							i_reg_wdata[pmac_pkg::BMCTL_NEGOTIATION_STRAP_ENABLE];
					end
					pmac_pkg::ADDR_ADV: state_next.negotiation_advertisement = i_reg_wdata[8:5];
					pmac_pkg::ADDR_PCS:
					begin
						state_next.fiber = i_reg_wdata[pmac_pkg::PCS_FIBER];
						state_next.fef = i_reg_wdata[pmac_pkg::PCS_FEF];
						state_next.scr_byp = i_reg_wdata[pmac_pkg::PCS_SCR_BYP];
						state_next.descr_byp =
							i_reg_wdata[pmac_pkg::PCS_DESCR_BYP];
					end
					default: ;
				endcase
			end
			// Clear on read comes first so a same-cycle event still sets
			if (i_reg_rd && i_reg_addr == pmac_pkg::ADDR_EXP)
			begin
				state_next.page_rx = 1'b0;
				state_next.pd_fault = 1'b0;
			end
			case (state_reg.st)
				pmac_pkg::PMAC_AN_IDLE:
				begin
					if (state_next.negotiation_strap_enable && (an_start || restart))
					begin
						state_next.st = pmac_pkg::PMAC_AN_ACTIVE;
						state_next.an_cpl = 1'b0;
						state_next.lpar = 16'h0000;
						state_next.lp_an_able = 1'b0;
					end
				end
				pmac_pkg::PMAC_AN_ACTIVE, pmac_pkg::PMAC_AN_DONE:
				begin
					if (!state_next.negotiation_strap_enable)
					begin
						state_next.st = pmac_pkg::PMAC_AN_IDLE;
						state_next.an_cpl = 1'b0;
					end
					else if (restart)
					begin
						state_next.st = pmac_pkg::PMAC_AN_ACTIVE;
						state_next.an_cpl = 1'b0;
						state_next.lpar = 16'h0000;
						state_next.lp_an_able = 1'b0;
					end
					else if (state_reg.st == pmac_pkg::PMAC_AN_DONE)
					begin
						// Lost link sends negotiation back to work
						if (!i_link_good)
						begin
							state_next.st = pmac_pkg::PMAC_AN_ACTIVE;
							state_next.an_cpl = 1'b0;
						end
					end
					else if (i_page_valid)
					begin
						state_next.lpar = i_page_word;
						state_next.page_rx = 1'b1;
						state_next.lp_an_able = 1'b1;
						if (!i_page_word[pmac_pkg::ADV_NP] && res_valid)
						begin
							state_next.st = pmac_pkg::PMAC_AN_DONE;
							state_next.an_cpl = 1'b1;
							state_next.res_spd = res_spd;
							state_next.res_fd = res_fd;
						end
					end
					else if (i_pd_link_100 && i_pd_link_10)
					begin
						state_next.pd_fault = 1'b1;
					end
					else if (i_pd_link_100 || i_pd_link_10)
					begin
						state_next.st = pmac_pkg::PMAC_AN_DONE;
						state_next.an_cpl = 1'b1;
						state_next.lp_an_able = 1'b0;
						state_next.res_spd = i_pd_link_100;
						state_next.res_fd = 1'b0;
						state_next.lpar = i_pd_link_100 ?
							pmac_pkg::LPAR_PD_100 : pmac_pkg::LPAR_PD_10;
					end
				end
				default: state_next.st = pmac_pkg::PMAC_AN_IDLE;
			endcase
		end
		// Read mux
		case (i_reg_addr)
			pmac_pkg::ADDR_BMCTL:
			begin
				rd[pmac_pkg::BMCTL_NEGOTIATION_STRAP_ENABLE] = state_reg.negotiation_strap_enable;
				rd[pmac_pkg::BMCTL_SPEED] = state_reg.speed;
				rd[pmac_pkg::BMCTL_DUPLEX] = state_reg.duplex;
			end
			pmac_pkg::ADDR_BMSTAT:
			begin
				rd = pmac_pkg::BMSTAT_FIXED;
				rd[pmac_pkg::BMSTAT_AN_CPL] = state_reg.an_cpl;
				rd[pmac_pkg::BMSTAT_RFAULT] = state_reg.lpar[pmac_pkg::ADV_RF];
				rd[pmac_pkg::BMSTAT_LINK] = state_reg.link;
			end
			pmac_pkg::ADDR_ADV: rd = {7'h00, state_reg.negotiation_advertisement, pmac_pkg::ADV_SELECTOR};
			pmac_pkg::ADDR_LPAR: rd = state_reg.lpar;
			pmac_pkg::ADDR_EXP:
			begin
				rd[pmac_pkg::EXP_PD_FAULT] = state_reg.pd_fault;
				rd[pmac_pkg::EXP_LP_NP] = state_reg.lpar[pmac_pkg::ADV_NP];
				rd[pmac_pkg::EXP_NP_ABLE] = 1'b1;
				rd[pmac_pkg::EXP_PAGE_RX] = state_reg.page_rx;
				rd[pmac_pkg::EXP_LP_AN] = state_reg.lp_an_able;
			end
			pmac_pkg::ADDR_PHY_LINK_STATUS:
			begin
				rd[pmac_pkg::PHY_LINK_STATUS_LINK] = state_reg.link;
				rd[pmac_pkg::PHY_LINK_STATUS_SPEED10] = !state_reg.spd;
				rd[pmac_pkg::PHY_LINK_STATUS_DUPLEX] = state_reg.fd;
				rd[pmac_pkg::PHY_LINK_STATUS_AN_CPL] = state_reg.an_cpl;
			end
			pmac_pkg::ADDR_PCS:
			begin
				rd[pmac_pkg::PCS_FIBER] = state_reg.fiber;
				rd[pmac_pkg::PCS_FEF] = state_reg.fef;
				rd[pmac_pkg::PCS_SCR_BYP] = state_reg.scr_byp;
				rd[pmac_pkg::PCS_DESCR_BYP] = state_reg.descr_byp;
			end
			default: rd = 16'h0000;
		endcase
		if (i_reg_rd)
		begin
			state_next.rdata = rd;
			state_next.rvalid = 1'b1;
		end
		// Speed, duplex, link, burst and advert outputs lag the state by one clock so each comes from a flop
		an_mode = state_reg.negotiation_strap_enable;
		state_next.spd = an_mode ? state_reg.res_spd : state_reg.speed;
		state_next.fd = an_mode ? state_reg.res_fd : state_reg.duplex;
		state_next.link = i_link_good && (!an_mode || state_reg.an_cpl);
		// Fiber has no pulse negotiation, so bursts stay off there
		state_next.flp = state_reg.st == pmac_pkg::PMAC_AN_ACTIVE &&
			!state_reg.fiber;
		state_next.adv = {7'h00, state_reg.negotiation_advertisement,
			pmac_pkg::ADV_SELECTOR};
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign o_reg_rdata = state_reg.rdata;
	assign o_reg_rvalid = state_reg.rvalid;
	assign o_flp_enable = state_reg.flp;
	assign o_adv_word = state_reg.adv;
	assign o_speed_100 = state_reg.spd;
	assign o_full_duplex = state_reg.fd;
	assign o_link_up = state_reg.link;
	assign o_fiber_mode = state_reg.fiber;
	assign o_fef_enable = state_reg.fef;
	assign o_scr_bypass = state_reg.scr_byp;
	assign o_descr_bypass = state_reg.descr_byp;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);

	a_fiber_strap: assert property (
		!state_reg.strap_done |=> o_fiber_mode == !$past(i_rxerr_strap))
		else $error("media strap not applied");
	a_fiber_bypass: assert property (
		(!state_reg.strap_done && !i_rxerr_strap) |=>
		o_fef_enable && o_scr_bypass && o_descr_bypass)
		else $error("fiber strap bits not set");
	a_fiber_write: assert property (
		(state_reg.strap_done && i_reg_wr && i_reg_addr == pmac_pkg::ADDR_PCS)
		|=> o_fiber_mode == $past(i_reg_wdata[pmac_pkg::PCS_FIBER]))
		else $error("fiber enable write lost");
	a_strap_adv: assert property (
		(!state_reg.strap_done && i_negotiation_strap_enable &&
		i_ability_strap_high && !i_ability_strap_low) |=> ##1
		o_adv_word[8:5] == pmac_pkg::ADV_100_F)
		else $error("strap advertisement wrong");
	a_forced_mode: assert property (
		(state_reg.strap_done && !state_reg.negotiation_strap_enable) |=>
		o_speed_100 == $past(state_reg.speed) &&
		o_full_duplex == $past(state_reg.duplex))
		else $error("forced mode not followed");
	a_best_mode: assert property (
		(state_reg.strap_done && state_reg.st == pmac_pkg::PMAC_AN_ACTIVE &&
		state_reg.negotiation_strap_enable && !i_reg_wr && i_page_valid &&
		!i_page_word[15] && state_reg.negotiation_advertisement[3] && i_page_word[8]) |=>
		state_reg.an_cpl ##1 (o_speed_100 && o_full_duplex))
		else $error("priority resolution wrong");
	a_page_capture: assert property (
		(state_reg.strap_done && state_reg.st == pmac_pkg::PMAC_AN_ACTIVE &&
		state_reg.negotiation_strap_enable && !i_reg_wr && i_page_valid) |=>
		state_reg.lpar == $past(i_page_word) && state_reg.lp_an_able)
		else $error("page not captured");
	a_pd_word: assert property (
		(state_reg.strap_done && state_reg.st == pmac_pkg::PMAC_AN_ACTIVE &&
		state_reg.negotiation_strap_enable && !i_reg_wr && !i_page_valid &&
		i_pd_link_100 && !i_pd_link_10) |=>
		state_reg.lpar == pmac_pkg::LPAR_PD_100 && !state_reg.lp_an_able)
		else $error("parallel detect word wrong");
	a_restart_an: assert property (
		(state_reg.strap_done && state_reg.st == pmac_pkg::PMAC_AN_DONE &&
		i_reg_wr && i_reg_addr == pmac_pkg::ADDR_BMCTL &&
		i_reg_wdata[12] && i_reg_wdata[9]) |=>
		state_reg.st == pmac_pkg::PMAC_AN_ACTIVE && !state_reg.an_cpl
		##1 o_flp_enable == !state_reg.fiber)
		else $error("restart ignored");
	a_status_fixed: assert property (
		(i_reg_rd && i_reg_addr == pmac_pkg::ADDR_BMSTAT) |=>
		o_reg_rvalid && o_reg_rdata[15:11] == 5'h0f && o_reg_rdata[3] &&
		o_reg_rdata[0] && o_reg_rdata[6])
		else $error("status ability bits wrong");
	a_phy_speed: assert property (
		(i_reg_rd && i_reg_addr == pmac_pkg::ADDR_PHY_LINK_STATUS) |=>
		o_reg_rdata[pmac_pkg::PHY_LINK_STATUS_SPEED10] == !$past(o_speed_100))
		else $error("status speed wrong");
endmodule // pmac_config

// ---- core/pmac_pkg.sv ----
// Purpose: Constants and types of the media and negotiation config block
// Assumes: 16-bit management registers at 5-bit addresses
// Notes: Bit positions are those of the management register layout
package pmac_pkg;
	// Register addresses
	localparam logic [4:0] ADDR_BMCTL = 5'h00;
	localparam logic [4:0] ADDR_BMSTAT = 5'h01;
	localparam logic [4:0] ADDR_ADV = 5'h04;
	localparam logic [4:0] ADDR_LPAR = 5'h05;
	localparam logic [4:0] ADDR_EXP = 5'h06;
	localparam logic [4:0] ADDR_PHY_LINK_STATUS = 5'h10;
	localparam logic [4:0] ADDR_PCS = 5'h16;
	// Basic mode control fields
	localparam int BMCTL_SPEED = 13;
	localparam int BMCTL_NEGOTIATION_STRAP_ENABLE = 12;
	localparam int BMCTL_RESTART = 9;
	localparam int BMCTL_DUPLEX = 8;
	// Basic mode status: fixed ability bits and live fields
	localparam logic [15:0] BMSTAT_FIXED = 16'h7849;
	localparam int BMSTAT_AN_CPL = 5;
	localparam int BMSTAT_RFAULT = 4;
	localparam int BMSTAT_LINK = 2;
	// Advertisement layout
	localparam int ADV_NP = 15;
	localparam int ADV_RF = 13;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam logic [3:0] ADV_ALL = 4'hf;
	localparam logic [3:0] ADV_10_HF = 4'h3;
	localparam logic [3:0] ADV_100_HF = 4'hc;
	localparam logic [3:0] ADV_100_F = 4'h8;
	// Partner word after parallel detection
	localparam logic [15:0] LPAR_PD_100 = 16'h0081;
	localparam logic [15:0] LPAR_PD_10 = 16'h0021;
	// Expansion fields
	localparam int EXP_PD_FAULT = 4;
	localparam int EXP_LP_NP = 3;
	localparam int EXP_NP_ABLE = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_LP_AN = 0;
	// PHY status fields
	localparam int PHY_LINK_STATUS_AN_CPL = 4;
	localparam int PHY_LINK_STATUS_DUPLEX = 2;
	localparam int PHY_LINK_STATUS_SPEED10 = 1;
	localparam int PHY_LINK_STATUS_LINK = 0;
	// PCS configuration fields
	localparam int PCS_FIBER = 6;
	localparam int PCS_FEF = 3;
	localparam int PCS_SCR_BYP = 1;
	localparam int PCS_DESCR_BYP = 0;
	// Negotiation states
	typedef enum logic [1:0] {
		PMAC_AN_IDLE = 2'b00,
		PMAC_AN_ACTIVE = 2'b01,
		PMAC_AN_DONE = 2'b10
	} pmac_an_st_t;
endpackage

// ---- core/pmac_resolve.sv ----
// Purpose: Highest common ability pick for negotiation
// Assumes: Ability order is 100 full, 100 half, 10 full, 10 half
// Notes: Pure combinational; the caller registers the result
`timescale 1ns/1ps
module pmac_resolve
(
	input wire logic [3:0] i_local,
	input wire logic [3:0] i_partner,
	output logic o_valid,
	output logic o_speed_100,
	output logic o_full
);
	logic [3:0] common;

	assign common = i_local & i_partner;

	always_comb
	begin
		o_valid = 1'b1;
		o_speed_100 = 1'b0;
		o_full = 1'b0;
		if (common[3])
		begin
			o_speed_100 = 1'b1;
			o_full = 1'b1;
		end
		else if (common[2])
		begin
			o_speed_100 = 1'b1;
		end
		else if (common[1])
		begin
			o_full = 1'b1;
		end
		else if (!common[0])
		begin
			// No shared ability: leave negotiation running
			o_valid = 1'b0;
		end
	end
endmodule // pmac_resolve

// ---- verification/pmac_partner_model.sv ----
// Purpose: Link partner model driving pages and detect links
// Assumes: Bench asks for a page with a one-cycle send request
// Notes: Idle page word toggles so a stale word never looks valid
`timescale 1ns/1ps
module pmac_partner_model
(
	input wire logic i_clk_sys,
	input wire logic i_send,
	input wire logic [15:0] i_word,
	input wire logic [1:0] i_pd_sel,
	input wire logic i_link,
	output logic o_page_valid,
	output logic [15:0] o_page_word,
	output logic o_pd_link_100,
	output logic o_pd_link_10,
	output logic o_link_good
);
	initial
	begin
		o_page_valid = 1'b0;
		o_page_word = 16'h0000;
	end
	always @(posedge i_clk_sys)
	begin
		o_page_valid <= i_send;
		o_page_word <= i_send ? i_word : ~o_page_word;
	end
	assign o_pd_link_100 = i_pd_sel[1];
	assign o_pd_link_10 = i_pd_sel[0];
	assign o_link_good = i_link;
endmodule // pmac_partner_model

// ---- verification/tb_phy_media_autoneg_config.sv ----
// Purpose: Self-checking bench for the media and negotiation block
// Assumes: Register reads answered one cycle later on o_reg_rvalid
// Notes: Reads queue their expectations; a monitor compares them
`timescale 1ns/1ps
module tb_phy_media_autoneg_config;
	logic clk = 1'b0, nrst = 1'b0, rx = 1'b1, ne = 1'b1, hi = 1'b0;
	logic lo = 1'b0, wr = 1'b0, rd_s = 1'b0, send = 1'b0, link = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000, word = 16'h0000, m_cur;
	logic [1:0] pd = 2'b00, res;
	logic pv, pd100, pd10, lgood, rvalid, flp, s100, full, lup;
	logic fib, fef, scr, dscr, rf;
	logic [15:0] rdata, adv, pw;
	logic [3:0] loc, par;
	logic [15:0] exp_q[$], msk_q[$];
	logic [4:0] adr_q[$];
	logic [3:0] tbl[4] = '{pmac_pkg::ADV_10_HF, pmac_pkg::ADV_100_HF,
		pmac_pkg::ADV_100_F, pmac_pkg::ADV_ALL};
	int failures = 0, checks_done = 0, cycles = 0, seed = 26;

	pmac_config u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_rxerr_strap(rx),
		.i_negotiation_strap_enable(ne), .i_ability_strap_high(hi),
		.i_ability_strap_low(lo), .i_reg_wr(wr), .i_reg_rd(rd_s),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_page_valid(pv),
		.i_page_word(pw), .i_pd_link_100(pd100), .i_pd_link_10(pd10),
		.i_link_good(lgood), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_flp_enable(flp), .o_adv_word(adv), .o_speed_100(s100),
		.o_full_duplex(full), .o_link_up(lup), .o_fiber_mode(fib),
		.o_fef_enable(fef), .o_scr_bypass(scr), .o_descr_bypass(dscr));
	pmac_partner_model u_partner (.i_clk_sys(clk), .i_send(send),
		.i_word(word), .i_pd_sel(pd), .i_link(link), .o_page_valid(pv),
		.o_page_word(pw), .o_pd_link_100(pd100), .o_pd_link_10(pd10),
		.o_link_good(lgood));

	initial
	begin
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic nclk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		nclk(1);
		wr = 1'b1;
		addr = a;
		wdata = d;
		nclk(1);
		wr = 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e,
		input logic [15:0] m = 16'hffff);
		nclk(1);
		rd_s = 1'b1;
		addr = a;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		adr_q.push_back(a);
		nclk(1);
		rd_s = 1'b0;
	endtask

	task automatic do_reset(input logic r, input logic n, input logic h,
		input logic l);
		nclk(1);
		nrst = 1'b0;
		{rx, ne, hi, lo} = {r, n, h, l};
		nclk(12);
		nrst = 1'b1;
		nclk(3);
	endtask

	function automatic logic [1:0] pick(input logic [3:0] c);
		if (c[3])
			return 2'b11;
		if (c[2])
			return 2'b10;
		if (c[1])
			return 2'b01;
		return 2'b00;
	endfunction

	always @(posedge clk)
	begin
		cycles++;
		if (rvalid === 1'b1 && exp_q.size() > 0)
		begin
			m_cur = msk_q.pop_front();
			chk($sformatf("reg_%h", adr_q.pop_front()), exp_q.pop_front(),
				rdata & m_cur);
		end
		else if (rvalid === 1'b1)
			chk("stray_rvalid", 16'h0, 16'h1);
		if (cycles == 5000)
		begin
			failures++;
			wrap_up();
		end
	end

	initial
	begin
		for (int s = 0; s < 4; s++)
		begin
			do_reset(1'b1, 1'b1, s[1], s[0]);
			rd(pmac_pkg::ADDR_ADV, {7'h0, tbl[s], 5'h01});
			chk("fiber_mode", 16'h0, 16'(fib));
		end
		for (int s = 0; s < 4; s++)
		begin
			do_reset(1'b0, 1'b0, s[1], s[0]);
			chk("speed_100", 16'(s[1]), 16'(s100));
			chk("full_duplex", 16'(s[0]), 16'(full));
			chk("pcs_outputs", 16'hf, 16'({fib, fef, scr, dscr}));
			rd(pmac_pkg::ADDR_PCS, 16'h004b);
			rd(pmac_pkg::ADDR_ADV, 16'h01e1);
			rd(pmac_pkg::ADDR_BMSTAT, 16'h7849, 16'hffcb);
		end
		wr_reg(pmac_pkg::ADDR_PCS, 16'h0000);
		rd(pmac_pkg::ADDR_PCS, 16'h0000);
		chk("fiber_mode", 16'h0, 16'(fib));
		wr_reg(5'h1f, 16'hffff);
		rd(5'h1f, 16'h0000);
		link = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			// First four walk each mode alone, the rest are random mixes
			loc = (i < 4) ? 4'hf : 4'($random(seed));
			par = (i < 4) ? 4'(1 << i) : 4'($random(seed));
			rf = 1'($random(seed));
			if (loc == 4'h0)
				loc = 4'h1;
			if ((loc & par) == 4'h0)
				par = loc;
			res = pick(loc & par);
			wr_reg(pmac_pkg::ADDR_ADV, {7'h0, loc, 5'h01});
			wr_reg(pmac_pkg::ADDR_BMCTL, 16'h1200);
			nclk(2);
			chk("flp_enable", 16'h1, 16'(flp));
			chk("adv_word", {7'h0, loc, 5'h01}, adv);
			nclk(1);
			send = 1'b1;
			word = {2'b00, rf, 4'h0, par, 5'h01};
			nclk(1);
			send = 1'b0;
			nclk(3);
			chk("speed_100", 16'(res[1]), 16'(s100));
			chk("full_duplex", 16'(res[0]), 16'(full));
			chk("link_up", 16'h1, 16'(lup));
			rd(pmac_pkg::ADDR_PHY_LINK_STATUS,
				{11'h0, 2'b10, res[0], ~res[1], 1'b1});
			rd(pmac_pkg::ADDR_LPAR, word);
			rd(pmac_pkg::ADDR_BMSTAT, 16'h786d | {11'h0, rf, 4'h0});
			rd(pmac_pkg::ADDR_EXP, 16'h0007);
			rd(pmac_pkg::ADDR_EXP, 16'h0005);
			rd(pmac_pkg::ADDR_BMCTL, 16'h1000);
		end
		wr_reg(pmac_pkg::ADDR_LPAR, 16'h0000);
		rd(pmac_pkg::ADDR_LPAR, word);
		for (int j = 0; j < 3; j++)
		begin
			wr_reg(pmac_pkg::ADDR_BMCTL, 16'h1200);
			pd = (j == 0) ? 2'b10 : ((j == 1) ? 2'b01 : 2'b11);
			nclk(3);
			if (j < 2)
			begin
				rd(pmac_pkg::ADDR_LPAR, (j == 0) ? pmac_pkg::LPAR_PD_100 :
					pmac_pkg::LPAR_PD_10);
				rd(pmac_pkg::ADDR_EXP, 16'h0000, 16'h0011);
				rd(pmac_pkg::ADDR_PHY_LINK_STATUS, (j == 0) ? 16'h0011 : 16'h0013);
			end
			else
				rd(pmac_pkg::ADDR_EXP, 16'h0010, 16'h0010);
			pd = 2'b00;
			nclk(1);
		end
		wr_reg(pmac_pkg::ADDR_PCS, 16'h0040);
		nclk(2);
		chk("fiber_mode", 16'h1, 16'(fib));
		chk("flp_enable", 16'h0, 16'(flp));
		for (int f = 0; f < 4; f++)
		begin
			wr_reg(pmac_pkg::ADDR_BMCTL, {2'b00, f[1], 4'h0, f[0], 8'h00});
			nclk(2);
			chk("speed_100", 16'(f[1]), 16'(s100));
			chk("full_duplex", 16'(f[0]), 16'(full));
		end
		nclk(3);
		chk("pending_reads", 16'h0, 16'(exp_q.size()));
		wrap_up();
	end
endmodule // tb_phy_media_autoneg_config
